// ---- hlu_consts.svh ----
/*
 * Constants of the host link block: clock rate, UART rates and
 * divisors, character layout and buffer depth.
 * Assumes a single system clock at the rate given here.
 */
`ifndef HLU_CONSTS_SVH
`define HLU_CONSTS_SVH

// System clock rate in Hz
`define HLU_CLK_HZ        25000000
// UART rate after start-up, bits per second
`define HLU_BAUD_START    115200
// Highest UART rate a host may switch to, bits per second
`define HLU_BAUD_MAX      3000000
// Cycles per bit at start-up rate
`define HLU_DIV_RST       (`HLU_CLK_HZ / `HLU_BAUD_START)
// Fewest cycles per bit; rounds up so the rate never exceeds the max
`define HLU_DIV_MIN       ((`HLU_CLK_HZ + `HLU_BAUD_MAX - 1) / `HLU_BAUD_MAX)
// Index of the last data bit of a character
`define HLU_LAST_BIT      7
// Highest serial clock the host may apply, Hz
`define HLU_SPI_MAX_HZ    20000000
// Words in the outbound buffer
`define HLU_FIFO_DEPTH    4
// Width of a buffered word
`define HLU_FIFO_WIDTH    8

`endif

// ---- hlu_pkg.sv ----
/*
 * Types of the host link block: pin groups and character states.
 * Assumes hlu_consts.svh supplies the numeric constants.
 */
package hlu_pkg;

    // UART pins coming from the host
    typedef struct packed {
        logic rx;          // Serial data from host
        logic hostReadyN;  // Host can take data, low active
    } hlu_uart_pins_t;

    // Serial port pins coming from the host, clock excluded
    typedef struct packed {
        logic selN;        // Frame select, low active
        logic mosi;        // Data from host
    } hlu_spi_pins_t;

    // One-hot character states for UART send and receive
    typedef enum logic [3:0] {
        CH_IDLE  = 4'b0001,
        CH_START = 4'b0010,
        CH_DATA  = 4'b0100,
        CH_STOP  = 4'b1000
    } hlu_char_state_t;

endpackage

// ---- hlu_top.sv ----
/*
 * Host link of a network processor: UART or serial slave port toward
 * an external host, an outbound word buffer, interrupt and hibernate.
 * Assumes the user side runs on clk; the serial port clock comes from
 * the host and stops outside frames.
 */
`include "hlu_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module hlu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,      // System clock
    input  wire logic             rst,      // Sync reset, high
    input  wire logic [WIDTH-1:0] inData,   // Word to store
    input  wire logic             inValid,  // Word offered
    output logic                  inReady,  // Room for a word
    output logic      [WIDTH-1:0] outData,  // Oldest word
    output logic                  outValid, // Buffer not empty
    input  wire logic             outReady  // Drain takes word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];   // Word storage
    logic [AW-1:0]    wrPtr_reg;     // Next slot to fill
    logic [AW-1:0]    rdPtr_reg;     // Oldest slot
    logic [CW-1:0]    count_reg;     // Words held
    logic [CW-1:0]    count_next;    // Words after this cycle
    logic             push;          // Word enters
    logic             pop;           // Word leaves

    // Advance a pointer with wrap for any depth
    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign push       = inValid && inReady;
    assign pop        = outValid && outReady;
    assign outData    = mem[rdPtr_reg];
    assign count_next = CW'(count_reg + CW'(push) - CW'(pop));

    // Storage write; data needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= nextPtr(wrPtr_reg);
            end
            if (pop) begin
                rdPtr_reg <= nextPtr(rdPtr_reg);
            end
            count_reg <= count_next;
        end
    end

    // Full and empty held in flops so the handshake is glitch free
    always_ff @(posedge clk) begin
        if (rst) begin
            inReady  <= 1'b0;
            outValid <= 1'b0;
        end else begin
            inReady  <= (count_next != CW'(DEPTH));
            outValid <= (count_next != '0);
        end
    end
endmodule // hlu_fifo

module hlu_top (
    input  wire logic                    clk,         // System clock
    input  wire logic                    sys_rst,     // Sync reset
    input  wire logic                    linkIsUart,  // 1 UART, 0 serial
    input  wire logic [15:0]             baudDivIn,   // New bit cycles
    input  wire logic                    baudLoad,    // Apply baudDivIn
    input  wire logic [7:0]              txData,      // Byte to host
    input  wire logic                    txValid,     // Byte offered
    output logic                         txReady,     // Buffer has room
    output logic [7:0]                   rxData,      // Byte from host
    output logic                         rxValid,     // One-cycle pulse
    input  wire logic                    rxAccept,    // User can take rx
    input  wire hlu_pkg::hlu_uart_pins_t uartPins,    // UART from host
    output logic                         uartTx,      // UART to host
    output logic                         devReadyN,   // Flow to host
    input  wire logic                    spiClk,      // Host serial clk
    input  wire hlu_pkg::hlu_spi_pins_t  spiPins,     // Select and mosi
    output logic                         spiMiso,     // Data to host
    output logic                         host_irq_out,    // To host
    input  wire logic                    hibernate_request_n, // Pin
    output logic                         hibernateActive  // Asleep
);
    import hlu_pkg::*;

    logic [2:0]       pinS1_reg;      // First stage, read by stage two
    logic [2:0]       pinS2_reg;      // Synced rx, hostReadyN, hib
    logic             rxPin;          // Synced UART rx
    logic             hostRdyN;       // Synced host flow line
    logic             hibPinN;        // Synced hibernate request
    logic             hib_reg;        // Device in hibernate
    logic [15:0]      div_reg;        // Cycles per bit in use
    logic [15:0]      pendDiv_reg;    // Rate awaiting idle line
    logic             pend_reg;       // A rate change is waiting
    logic [7:0]       fifoData;       // Oldest outbound byte
    logic             fifoValid;      // Outbound byte present
    logic             fifoPop;        // Drain takes the byte
    logic             popUart;        // UART takes the byte
    logic             popSpi;         // Serial port takes the byte
    hlu_char_state_t  txSt_reg;       // UART send state
    logic [15:0]      txTmr_reg;      // Send bit timer
    logic [2:0]       txCnt_reg;      // Send bit index
    logic [7:0]       txSh_reg;       // Send shifter
    hlu_char_state_t  rxSt_reg;       // UART receive state
    logic [15:0]      rxTmr_reg;      // Receive bit timer
    logic [2:0]       rxCnt_reg;      // Receive bit index
    logic [7:0]       rxSh_reg;       // Receive shifter
    logic             uDone_reg;      // UART byte complete, pulse
    logic             rstHold_reg;    // Reset for the link domain
    logic             spiRst;         // Link domain clear
    logic             spiSelN;        // Frame select from host
    logic [2:0]       sBit_reg;       // Link bit index
    logic [7:0]       sRxSh_reg;      // Link receive shifter
    logic [7:0]       sRxHold_reg;    // Last byte from host
    logic             sRxTog_reg;     // Flips per received byte
    logic             sReq1_reg;      // First stage of request sync
    logic             sReq2_reg;      // Synced request toggle
    logic             sAck_reg;       // Flips when a byte is taken
    logic [7:0]       sTxSh_reg;      // Link send shifter
    logic [7:0]       sByte;          // Byte starting on the wire
    logic [2:0]       rTog_reg;       // Sync of receive toggle
    logic [1:0]       aTog_reg;       // Sync of acknowledge toggle
    logic             req_reg;        // Flips per byte handed over
    logic [7:0]       txHold_reg;     // Byte handed to link domain

    // Plain names for the synced pins
    assign rxPin    = pinS2_reg[2];
    assign hostRdyN = pinS2_reg[1];
    assign hibPinN  = pinS2_reg[0];

    // Two flops on every pin from outside the clock domain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinS1_reg <= 3'h7;
            pinS2_reg <= 3'h7;
        end else begin
            pinS1_reg <= {uartPins.rx, uartPins.hostReadyN,
                          hibernate_request_n};
            pinS2_reg <= pinS1_reg;
        end
    end

    // Hibernate follows the request level both ways
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hib_reg <= 1'b0;
        end else begin
            hib_reg <= !hibPinN;
        end
    end
    assign hibernateActive = hib_reg;

    // Bit rate: fixed start rate, host may switch it later. A change
    // waits for both lines to idle; a character starting in the cycle it applies has its start bit at the old rate.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_reg     <= 16'(`HLU_DIV_RST);
            pendDiv_reg <= 16'(`HLU_DIV_RST);
            pend_reg    <= 1'b0;
        end else begin
            if (baudLoad) begin
                // Clamp keeps the rate at or below the ceiling
                pendDiv_reg <= (baudDivIn < 16'(`HLU_DIV_MIN)) ?
                               16'(`HLU_DIV_MIN) : baudDivIn;
                pend_reg    <= 1'b1;
            end else if (pend_reg && txSt_reg == CH_IDLE &&
                         rxSt_reg == CH_IDLE) begin
                div_reg  <= pendDiv_reg;
                pend_reg <= 1'b0;
            end
        end
    end

    // Outbound buffer between user and the active link
    hlu_fifo #(
        .WIDTH (`HLU_FIFO_WIDTH),
        .DEPTH (`HLU_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (sys_rst),
        .inData   (txData),
        .inValid  (txValid),
        .inReady  (txReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    // UART drains only when idle, host ready and awake
    assign popUart = linkIsUart && fifoValid && !hib_reg &&
                     txSt_reg == CH_IDLE && !hostRdyN;
    // Serial port drains when the last hand-over was acknowledged
    assign popSpi  = !linkIsUart && fifoValid && !hib_reg &&
                     aTog_reg[1] == req_reg;
    assign fifoPop = popUart || popSpi;

    // UART send: start, eight data bits LSB first, one stop, no parity
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txSt_reg  <= CH_IDLE;
            uartTx    <= 1'b1;
            txTmr_reg <= 16'h0000;
            txCnt_reg <= 3'h0;
            txSh_reg  <= 8'h00;
        end else begin
            unique case (txSt_reg)
                CH_IDLE: begin
                    uartTx <= 1'b1;
                    if (popUart) begin
                        txSh_reg  <= fifoData;
                        uartTx    <= 1'b0;
                        txTmr_reg <= 16'(div_reg - 16'h0001);
                        txSt_reg  <= CH_START;
                    end
                end
                CH_START: begin
                    if (txTmr_reg == 16'h0000) begin
                        uartTx    <= txSh_reg[0];
                        txSh_reg  <= {1'b0, txSh_reg[7:1]};
                        txCnt_reg <= 3'h0;
                        txTmr_reg <= 16'(div_reg - 16'h0001);
                        txSt_reg  <= CH_DATA;
                    end else begin
                        txTmr_reg <= 16'(txTmr_reg - 16'h0001);
                    end
                end
                CH_DATA: begin
                    if (txTmr_reg != 16'h0000) begin
                        txTmr_reg <= 16'(txTmr_reg - 16'h0001);
                    end else if (txCnt_reg == 3'(`HLU_LAST_BIT)) begin
                        uartTx    <= 1'b1;
                        txTmr_reg <= 16'(div_reg - 16'h0001);
                        txSt_reg  <= CH_STOP;
                    end else begin
                        uartTx    <= txSh_reg[0];
                        txSh_reg  <= {1'b0, txSh_reg[7:1]};
                        txCnt_reg <= 3'(txCnt_reg + 3'h1);
                        txTmr_reg <= 16'(div_reg - 16'h0001);
                    end
                end
                CH_STOP: begin
                    if (txTmr_reg == 16'h0000) begin
                        txSt_reg <= CH_IDLE;
                    end else begin
                        txTmr_reg <= 16'(txTmr_reg - 16'h0001);
                    end
                end
            endcase
        end
    end

    // UART receive: sample mid-bit; a bad stop bit drops the byte
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxSt_reg  <= CH_IDLE;
            rxTmr_reg <= 16'h0000;
            rxCnt_reg <= 3'h0;
            rxSh_reg  <= 8'h00;
            uDone_reg <= 1'b0;
        end else begin
            uDone_reg <= 1'b0;
            unique case (rxSt_reg)
                CH_IDLE: begin
                    if (!rxPin) begin
                        rxTmr_reg <= {1'b0, div_reg[15:1]};
                        rxSt_reg  <= CH_START;
                    end
                end
                CH_START: begin
                    if (rxTmr_reg != 16'h0000) begin
                        rxTmr_reg <= 16'(rxTmr_reg - 16'h0001);
                    end else if (!rxPin) begin
                        rxCnt_reg <= 3'h0;
                        rxTmr_reg <= 16'(div_reg - 16'h0001);
                        rxSt_reg  <= CH_DATA;
                    end else begin
                        // Glitch, not a start bit
                        rxSt_reg <= CH_IDLE;
                    end
                end
                CH_DATA: begin
                    if (rxTmr_reg != 16'h0000) begin
                        rxTmr_reg <= 16'(rxTmr_reg - 16'h0001);
                    end else begin
                        rxSh_reg  <= {rxPin, rxSh_reg[7:1]};
                        rxTmr_reg <= 16'(div_reg - 16'h0001);
                        rxCnt_reg <= 3'(rxCnt_reg + 3'h1);
                        if (rxCnt_reg == 3'(`HLU_LAST_BIT)) begin
                            rxSt_reg <= CH_STOP;
                        end
                    end
                end
                CH_STOP: begin
                    if (rxTmr_reg != 16'h0000) begin
                        rxTmr_reg <= 16'(rxTmr_reg - 16'h0001);
                    end else begin
                        uDone_reg <= rxPin;
                        rxSt_reg  <= CH_IDLE;
                    end
                end
            endcase
        end
    end

    // Flow line to host: not ready while asleep or user is full
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            devReadyN <= 1'b1;
        end else begin
            devReadyN <= hib_reg || !rxAccept;
        end
    end

    // Interrupt asks the host to collect waiting data, on either
    // link; it is the fifth UART wire that lets the host sleep
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_irq_out <= 1'b0;
        end else begin
            host_irq_out <= fifoValid && !hib_reg;
        end
    end

    // Received bytes pass on in arrival order; multi-byte values keep
    // their little-endian order because nothing here reorders them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxValid <= 1'b0;
            rxData  <= 8'h00;
        end else begin
            rxValid <= 1'b0;
            if (linkIsUart && uDone_reg) begin
                rxValid <= 1'b1;
                rxData  <= rxSh_reg;
            end else if (!linkIsUart && rTog_reg[2] != rTog_reg[1]) begin
                rxValid <= 1'b1;
                rxData  <= sRxHold_reg;
            end
        end
    end

    // Hand a byte to the link domain; held until acknowledged
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_reg     <= 1'b0;
            txHold_reg  <= 8'h00;
            rstHold_reg <= 1'b1;
        end else begin
            rstHold_reg <= 1'b0;
            if (popSpi) begin
                txHold_reg <= fifoData;
                req_reg    <= !req_reg;
            end
        end
    end

    // Toggle syncs from the link domain; stage one is read only by two
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rTog_reg <= 3'h0;
            aTog_reg <= 2'h0;
        end else begin
            rTog_reg <= {rTog_reg[1:0], sRxTog_reg};
            aTog_reg <= {aTog_reg[0], sAck_reg};
        end
    end

    // Link domain: four pins only, clock, select, mosi and miso.
    // Select high clears the bit index so each frame starts clean.
    assign spiRst  = rstHold_reg;
    assign spiSelN = spiPins.selN;

    // Bit index advances on falling edges inside a frame
    always_ff @(negedge spiClk or posedge spiSelN) begin
        if (spiSelN) begin
            sBit_reg <= 3'h0;
        end else begin
            sBit_reg <= 3'(sBit_reg + 3'h1);
        end
    end

    // Host data sampled on the falling edge
    always_ff @(negedge spiClk) begin
        sRxSh_reg <= {sRxSh_reg[6:0], spiPins.mosi};
        if (!spiSelN && sBit_reg == 3'(`HLU_LAST_BIT)) begin
            sRxHold_reg <= {sRxSh_reg[6:0], spiPins.mosi};
        end
    end

    // Receive toggle; the byte stays in sRxHold_reg for a whole byte
    // time, which at the top serial rate is far longer than the sync
    always_ff @(negedge spiClk or posedge spiRst) begin
        if (spiRst) begin
            sRxTog_reg <= 1'b0;
        end else if (!spiSelN && sBit_reg == 3'(`HLU_LAST_BIT)) begin
            sRxTog_reg <= !sRxTog_reg;
        end
    end

    // Byte to send: the handed-over one if fresh, else zero filler
    assign sByte = (sReq2_reg != sAck_reg) ? txHold_reg : 8'h00;

    // Request sync and acknowledge, on rising edges of the link clock
    always_ff @(posedge spiClk or posedge spiRst) begin
        if (spiRst) begin
            sReq1_reg <= 1'b0;
            sReq2_reg <= 1'b0;
            sAck_reg  <= 1'b0;
        end else begin
            sReq1_reg <= req_reg;
            sReq2_reg <= sReq1_reg;
            if (!spiSelN && sBit_reg == 3'h0) begin
                sAck_reg <= sReq2_reg;
            end
        end
    end

    // Answer driven MSB first on rising edges, host samples falling
    always_ff @(posedge spiClk or posedge spiRst) begin
        if (spiRst) begin
            spiMiso   <= 1'b0;
            sTxSh_reg <= 8'h00;
        end else if (sBit_reg == 3'h0) begin
            spiMiso   <= sByte[7];
            sTxSh_reg <= {sByte[6:0], 1'b0};
        end else begin
            spiMiso   <= sTxSh_reg[7];
            sTxSh_reg <= {sTxSh_reg[6:0], 1'b0};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_rate_at_start: assert property ($past(sys_rst) |->
        div_reg == 16'(`HLU_DIV_RST)) else $error("start rate wrong");
    a_rate_ceiling: assert property (div_reg >=
        16'(`HLU_DIV_MIN)) else $error("bit rate above ceiling");
    a_start_bit_low: assert property (txSt_reg == CH_START
        |-> !uartTx) else $error("start bit not low");
    a_stop_bit_high: assert property ($rose(txSt_reg == CH_STOP)
        |-> uartTx && $past(txCnt_reg) == 3'(`HLU_LAST_BIT))
        else $error("stop bit wrong");
    a_send_needs_host: assert property (
        $rose(txSt_reg == CH_START) |-> $past(!hostRdyN))
        else $error("sent while host busy");
    a_irq_high_data: assert property (fifoValid && !hib_reg
        ##1 fifoValid && !hib_reg |-> host_irq_out)
        else $error("interrupt missing");
    a_irq_quiet_hib: assert property (hib_reg ##1 hib_reg
        |-> !host_irq_out) else $error("interrupt while asleep");
    a_hib_follows_pin: assert property (!hibPinN[*3]
        |-> hib_reg && devReadyN) else $error("hibernate not entered");
    a_hib_no_send: assert property (
        hib_reg && txSt_reg == CH_IDLE |=> txSt_reg == CH_IDLE)
        else $error("sent in hibernate");
endmodule // hlu_top

`default_nettype wire

// ---- hlu_host_model.sv ----
/* Host side UART model: decodes device characters, sends characters.
   Assumes the bench sets the bit time whenever the rate changes. */
`timescale 1ns/100ps
`default_nettype none
module hlu_host_model #(
    parameter int BIT = 217             // Cycles per bit
) (
    input  wire logic clk,              // System clock
    input  wire logic txLine,           // Device UART out
    output logic      rxLine            // Host UART out
);
    logic [7:0] got [$];                // Bytes decoded from device
    logic [7:0] sh;                     // Shift of bits seen
    int         bitCycles = BIT;        // Cycles per bit now in use
    initial rxLine = 1'b1;
    // Sample mid bit; a bad stop bit drops the byte, as a host would.
    // Always listening and never full, so no character is lost
    always begin
        @(negedge txLine);
        repeat (bitCycles / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bitCycles) @(posedge clk);
            sh[i] = txLine;
        end
        repeat (bitCycles) @(posedge clk);
        if (txLine === 1'b1) got.push_back(sh);
    end
    // Start, eight bits LSB first, stop
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rxLine <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (bitCycles) @(posedge clk);
        end
    endtask
endmodule // hlu_host_model
`default_nettype wire

// ---- host_link_uart_spi_test.sv ----
/* Self-checking bench of hlu_top: reset, buffer, UART, serial, sleep.
   Assumes hlu_pkg and the host model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "hlu_consts.svh"
module host_link_uart_spi_test;
    import hlu_pkg::*;
    logic clk, sysRst, isUart, bLoad, txValid, rxAccept, spiClk, hibN;
    logic txReady, rxValid, uartTx, devReadyN, miso, irq, hibAct;
    logic hostRx, hostRdyN, selN, mosi;
    logic [7:0] txData, rxData;
    logic [15:0] bDiv, spiIn;
    int nErrors, nChecks;
    hlu_uart_pins_t uPins;
    hlu_spi_pins_t sPins;
    assign uPins = '{hostRx, hostRdyN};
    assign sPins = '{selN, mosi};
    hlu_top u_hlu_top (.clk(clk), .sys_rst(sysRst), .linkIsUart(isUart),
        .baudDivIn(bDiv), .baudLoad(bLoad), .txData(txData),
        .txValid(txValid), .txReady(txReady), .rxData(rxData),
        .rxValid(rxValid), .rxAccept(rxAccept), .uartPins(uPins),
        .uartTx(uartTx), .devReadyN(devReadyN), .spiClk(spiClk),
        .spiPins(sPins), .spiMiso(miso), .host_irq_out(irq),
        .hibernate_request_n(hibN), .hibernateActive(hibAct));
    hlu_host_model u_hlu_host_model (.clk(clk), .txLine(uartTx),
        .rxLine(hostRx));
    initial begin clk = 0; forever #20 clk = ~clk; end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Offer a byte; valid stays up for back-to-back pushes
    task automatic push(input logic [7:0] b);
        txData <= b;
        txValid <= 1;
        @(negedge clk);
        while (txReady !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask
    // Fill with host stalled, then drain over UART in order
    task automatic t_fill;
        hostRdyN <= 1;
        for (int i = 0; i < 4; i++) push(8'hA1 + 8'(i));
        txValid <= 0;
        @(negedge clk);
        check({7'h00, txReady}, 8'h00);
        check({7'h00, irq}, 8'h01);
        @(posedge clk) hostRdyN <= 0;
        repeat (12000) @(posedge clk)
            if (u_hlu_host_model.got.size() == 4) break;
        for (int i = 0; i < 4; i++)
            check(u_hlu_host_model.got[i],
                  8'hA1 + 8'(i));
        @(negedge clk) check({7'h00, irq}, 8'h00);
        $display("fill and drain done");
    endtask
    // Host character in, one pulse out
    task automatic t_rx;
        fork
            u_hlu_host_model.send(8'h3C);
            begin
                repeat (3000) @(negedge clk) if (rxValid === 1'b1) break;
                check(rxData, 8'h3C);
            end
        join
        $display("uart receive done");
    endtask
    // Two-byte frame, MSB first. The hand-over crosses on link edges
    // only, so the first byte out is filler and the buffered one next
    task automatic t_spi;
        logic [15:0] spiOut;
        spiOut = 16'hC396;
        @(posedge clk) isUart <= 0;
        push(8'h5A);
        txValid <= 0;
        repeat (20) @(posedge clk);
        fork
            begin
                #13 selN = 0;
                for (int i = 15; i >= 0; i--) begin
                    #32 spiClk = 1;
                    #4 mosi = spiOut[i];
                    #28 spiClk = 0;
                    spiIn = {spiIn[14:0], miso};
                end
                #32 selN = 1;
            end
            for (int k = 1; k >= 0; k--) begin
                repeat (40) @(negedge clk) if (rxValid === 1'b1) break;
                check(rxData, spiOut[8*k +: 8]);
                @(negedge clk);
            end
        join
        check(spiIn[15:8], 8'h00);
        check(spiIn[7:0], 8'h5A);
        $display("serial frame done");
    endtask
    // Sleep pin low then high
    task automatic t_hib;
        @(posedge clk) hibN <= 0;
        repeat (5) @(posedge clk);
        check({6'h00, devReadyN, hibAct}, 8'h03);
        hibN <= 1;
        repeat (5) @(posedge clk);
        check({7'h00, hibAct}, 8'h00);
        $display("hibernate done");
    endtask
    // Rate asked above the ceiling is clamped; both ends then agree
    task automatic t_baud;
        @(posedge clk) isUart <= 1;
        bDiv <= 16'h0004;
        bLoad <= 1;
        @(posedge clk) bLoad <= 0;
        repeat (4) @(posedge clk);
        u_hlu_host_model.bitCycles = `HLU_DIV_MIN;
        push(8'h96);
        txValid <= 0;
        u_hlu_host_model.send(8'h69);
        repeat (100) @(posedge clk);
        check(rxData, 8'h69);
        check(u_hlu_host_model.got[4], 8'h96);
        $display("rate change done");
    endtask
    initial begin
        {isUart, sysRst, hibN, hostRdyN, rxAccept, selN} = 6'h3E;
        {bLoad, txValid, spiClk, mosi, txData, spiIn, bDiv} = '0;
        repeat (8) @(posedge clk);
        check({2'h0, uartTx, devReadyN, irq, rxValid, hibAct, txReady}, 8'h30);
        sysRst <= 0;
        selN <= 1;
        repeat (2) @(posedge clk);
        t_fill;
        t_rx;
        t_spi;
        t_hib;
        t_baud;
        give_verdict;
    end
    initial begin #1ms; nErrors++; give_verdict; end
endmodule // host_link_uart_spi_test
`default_nettype wire
